/* bench/aer_regs_properties.sv */
// checker for the error-report mask/control and serial register slice
// assumes it sees only the top module ports; bound at the foot
`timescale 1ns/1ns
module aer_regs_chk (
  input wire clk_i,
  input wire rst_i,
  input wire cold_rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [11:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire err_o,
  input wire [31:0] corr_event_i,
  input wire corr_report_o,
  input wire crc_gen_enable_o,
  input wire crc_check_enable_o
);
  // a request is taken whenever it is not already being answered
  wire tk = cyc_i & stb_i & !ack_o;
  wire wc = tk & we_i & (adr_i == 12'h118);
  wire rq = tk & !we_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i || cold_rst_i);
  a_ack_next: assert property (tk |=> ack_o)
    else $error("request not answered");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than a cycle");
  a_err_quiet: assert property (!err_o)
    else $error("bus error raised");
  a_report_cause: assert property (
    corr_report_o |-> (corr_event_i & 32'h31c1) != 32'h0)
    else $error("report without event");
  a_gen_write: assert property (
    wc && sel_i[0] |=> crc_gen_enable_o == $past(dat_i[6]))
    else $error("generate enable not written");
  a_chk_write: assert property (
    wc && sel_i[1] |=> crc_check_enable_o == $past(dat_i[8]))
    else $error("check enable not written");
  a_en_hold: assert property (
    !wc |=> $stable({crc_gen_enable_o, crc_check_enable_o}))
    else $error("enables moved without write");
  a_cap_read: assert property (
    rq && adr_i == 12'h180 |=> dat_o[19:0] == 20'h10003)
    else $error("capability header wrong");
  a_ctl_resv: assert property (
    rq && adr_i == 12'h118 |=> dat_o[31:9] == 23'h0)
    else $error("control reserved bits set");
  a_mask_resv: assert property (
    rq && adr_i == 12'h114 |=> (dat_o & ~32'h31c1) == 32'h0)
    else $error("mask reserved bits set");
  c_report: cover property (corr_report_o);
  c_ctl_write: cover property (wc);
  c_cap_read: cover property (rq && adr_i == 12'h180);
endmodule
bind aer_mask_ctl_serial_regs aer_regs_chk chk (.*);

/* bench/rc_model.sv */
// root complex side: classic wishbone master for config accesses
// assumes a slave that acks once per request
`timescale 1ns/1ns
module rc_model (
  // clock
  input wire clk_i,
  // answer
  input wire ack_i,
  input wire [31:0] dat_i,
  // request
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [11:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  initial begin
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  end
  // random idle gaps let the slave see both quick and slow masters
  task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q);
    repeat ($urandom % 3) @(posedge clk_i);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, 4'hf, d};
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    {cyc_o, stb_o} <= 2'b00;
    dat_o <= ~d; // released data must not look valid
  endtask
endmodule

/* bench/tb_top.sv */
// self-checking bench for the error-report/serial register slice
// assumes rc_model as bus master and a bound checker
`timescale 1ns/1ns
module tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, cold_rst_i = 1'b1;
  logic lock_open_i = 1'b0, uncorr_err_i = 1'b0;
  logic [4:0] uncorr_bit_i = 5'h0;
  logic [31:0] corr_event_i = 32'h0;
  logic [127:0] uncorr_header_i = 128'h0;
  wire cyc_i, stb_i, we_i, ack_o, err_o, corr_report_o;
  wire crc_gen_enable_o, crc_check_enable_o;
  wire [11:0] adr_i;
  wire [3:0] sel_i;
  wire [31:0] dat_i, dat_o;
  int error_cnt = 0, num_checks = 0;
  int pos[6] = '{0, 6, 7, 8, 12, 13};
  logic [31:0] q, m, mask_m, ctl, ser;
  logic [127:0] h;
  always #5 clk_i = ~clk_i;
  aer_mask_ctl_serial_regs uut (.*);
  rc_model rc (.clk_i, .ack_i(ack_o), .dat_i(dat_o), .cyc_o(cyc_i),
    .stb_o(stb_i), .we_o(we_i), .adr_o(adr_i), .sel_o(sel_i),
    .dat_o(dat_i));
  task cmp(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    rc.xfer(1'b0, a, 32'h0, q);
    cmp(q, e);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    rc.xfer(1'b1, a, d, q);
  endtask
  // mask, control, header log, capability, serial and enable state against the model
  task chkall;
    rd(12'h114, mask_m);
    rd(12'h118, ctl);
    for (int i = 0; i < 4; i++) rd(12'h11c + 12'(4*i), h[32*i+:32]);
    rd(12'h180, 32'h0001_0003);
    rd(12'h184, ser);
    rd(12'h1fc, 32'h0);
    cmp({crc_check_enable_o, crc_gen_enable_o}, {ctl[8], ctl[6]});
  endtask
  task results;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h7499c04c));
    repeat (5) @(posedge clk_i);
    {rst_i, cold_rst_i} <= 2'b00;
    {mask_m, ctl, ser, h} = {32'h2000, 32'ha0, 32'h0, 128'h0};
    chkall;
    $display("reset values done");
    m = $urandom;
    wr(12'h114, m);
    wr(12'h118, m);
    wr(12'h184, m);
    {mask_m, ctl} = {m & 32'h31c1, (m & 32'h140) | 32'ha0};
    chkall;
    lock_open_i <= 1'b1;
    wr(12'h118, 32'h140);
    wr(12'h184, m);
    {ctl, ser} = {32'h140, m};
    chkall;
    $display("lock test done");
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_i) corr_event_i <= 32'h1 << pos[i];
      #1 cmp({31'h0, corr_report_o}, {31'h0, ~mask_m[pos[i]]});
    end
    @(posedge clk_i) corr_event_i <= 32'h0;
    rd(12'h110, 32'h31c1);
    wr(12'h110, 32'h31c1);
    rd(12'h110, 32'h0);
    $display("mask test done");
    h = {$urandom, $urandom, $urandom, $urandom};
    ctl[4:0] = 5'd12 + 5'($urandom % 9);
    @(posedge clk_i) {uncorr_err_i, uncorr_bit_i, uncorr_header_i} <= {1'b1, ctl[4:0], h};
    @(posedge clk_i) {uncorr_bit_i, uncorr_header_i} <= {5'd4, ~h};
    @(posedge clk_i) uncorr_err_i <= 1'b0;
    chkall;
    rd(12'h104, 32'h1);
    wr(12'h104, 32'h1);
    rd(12'h104, 32'h0);
    rd(12'h140, 32'h1);
    $display("log test done");
    @(posedge clk_i) rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    ctl = ctl | 32'ha0;
    chkall;
    $display("hot reset done");
    results;
  end
  // a few hundred bus cycles are expected; this is far beyond that
  initial begin
    #200000;
    error_cnt++;
    results;
  end
endmodule

/* hdl/aer_mask_ctl_serial_regs.v */
// error-report mask/control, header log and serial number registers
// assumes classic wishbone master, byte addresses, one word per register
`timescale 1ns/1ns
`include "aer_serial_map.vh"
module aer_mask_ctl_serial_regs (
  // clock and resets
  input wire clk_i,
  input wire rst_i,
  input wire cold_rst_i,
  // wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [11:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output wire err_o,
  // lockable write permit
  input wire lock_open_i,
  // correctable events from link layers
  input wire [31:0] corr_event_i,
  output wire corr_report_o,
  // uncorrectable first-error capture
  input wire uncorr_err_i,
  input wire [4:0] uncorr_bit_i,
  input wire [127:0] uncorr_header_i,
  // datapath controls
  output wire crc_gen_enable_o,
  output wire crc_check_enable_o
);
  reg [31:0] correctable_error_mask;
  reg crc_gen_capable;
  reg crc_gen_enable;
  reg crc_check_capable;
  reg crc_check_enable;
  reg [11:0] next_capability_pointer;
  reg [31:0] serial_number_low;
  wire [31:0] correctable_status_reg;
  wire [4:0] first_error_pointer;
  wire [127:0] header_log_field;
  wire log_held;
  wire req;
  wire wr;
  wire [31:0] wmask;
  wire [31:0] corr_clear;
  wire hit;
  reg [31:0] rdata;

  // byte enables widen to a bit mask
  function [31:0] lanes;
    input [3:0] s;
    begin
      lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    end
  endfunction

  // a sticky write merges selected lanes only
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [31:0] m;
    begin
      merge = (old & ~m) | (data & m);
    end
  endfunction

  assign req = cyc_i && stb_i && !ack_o;
  assign wr = req && we_i;
  assign wmask = lanes(sel_i);
  assign corr_clear = (wr && adr_i == `OFF_CORR_STATUS) ?
    (dat_i & wmask) : 32'h0000_0000;
  assign crc_gen_enable_o = crc_gen_enable;
  assign crc_check_enable_o = crc_check_enable;

  corr_status_bank #(
    .WIDTH(32)
  ) u_status (
    .clk_i(clk_i),
    .cold_rst_i(cold_rst_i),
    .event_i(corr_event_i),
    .clear_i(corr_clear),
    .mask_i(correctable_error_mask),
    .used_i(`CORR_USED_MASK),
    .status_o(correctable_status_reg),
    .report_o(corr_report_o)
  );

  // rearm when software writes the uncorrectable status word with bit 0 set
  first_error_log #(
    .DW(32)
  ) u_log (
    .clk_i(clk_i),
    .cold_rst_i(cold_rst_i),
    .err_i(uncorr_err_i),
    .err_bit_i(uncorr_bit_i),
    .header_i(uncorr_header_i),
    .rearm_i(wr && adr_i == `OFF_UNCORR_STATUS && sel_i[0] && dat_i[0]),
    .pointer_o(first_error_pointer),
    .log_o(header_log_field),
    .held_o(log_held)
  );

  // sticky fields only react to the cold reset, hot reset leaves them
  always @(posedge clk_i) begin
    if (cold_rst_i) begin
      correctable_error_mask <= `CORR_MASK_RESET;
      crc_gen_enable <= 1'b0;
      crc_check_enable <= 1'b0;
      serial_number_low <= 32'h0000_0000;
    end else if (wr) begin
      case (adr_i)
        `OFF_CORR_MASK: begin
          correctable_error_mask <= merge(correctable_error_mask, dat_i,
            wmask & `CORR_USED_MASK);
        end
        `OFF_ERR_CTL: begin
          if (sel_i[0]) begin
            crc_gen_enable <= dat_i[`CTL_GEN_EN];
          end
          if (sel_i[1]) begin
            crc_check_enable <= dat_i[`CTL_CHK_EN];
          end
        end
        `OFF_SER_LOW: begin
          if (lock_open_i) begin
            serial_number_low <= merge(serial_number_low, dat_i,
              wmask);
          end
        end
        default: begin
        end
      endcase
    end
  end

  // non-sticky lockable fields return to defaults on any reset
  always @(posedge clk_i) begin
    if (rst_i || cold_rst_i) begin
      crc_gen_capable <= 1'b1;
      crc_check_capable <= 1'b1;
      next_capability_pointer <= `NEXT_PTR_RESET;
    end else if (wr && lock_open_i) begin
      if (adr_i == `OFF_ERR_CTL && sel_i[0]) begin
        crc_gen_capable <= dat_i[`CTL_GEN_CAP];
        crc_check_capable <= dat_i[`CTL_CHK_CAP];
      end
      if (adr_i == `OFF_SER_CAP) begin
        if (sel_i[2]) begin
          next_capability_pointer[3:0] <= dat_i[23:20];
        end
        if (sel_i[3]) begin
          next_capability_pointer[11:4] <= dat_i[31:24];
        end
      end
    end
  end

  // read mux; reserved bits and unmapped words return zero
  always @* begin
    rdata = 32'h0000_0000;
    case (adr_i)
      `OFF_CORR_STATUS: rdata = correctable_status_reg;
      `OFF_CORR_MASK: rdata = correctable_error_mask & `CORR_USED_MASK;
      `OFF_ERR_CTL: begin
        rdata[4:0] = first_error_pointer;
        rdata[`CTL_GEN_CAP] = crc_gen_capable;
        rdata[`CTL_GEN_EN] = crc_gen_enable;
        rdata[`CTL_CHK_CAP] = crc_check_capable;
        rdata[`CTL_CHK_EN] = crc_check_enable;
      end
      `OFF_HDR_LOG1: rdata = header_log_field[31:0];
      `OFF_HDR_LOG2: rdata = header_log_field[63:32];
      `OFF_HDR_LOG3: rdata = header_log_field[95:64];
      `OFF_HDR_LOG4: rdata = header_log_field[127:96];
      `OFF_UNCORR_STATUS: rdata = {31'h0000_0000, log_held};
      `OFF_LOCK_CTL: rdata = {31'h0000_0000, lock_open_i};
      `OFF_SER_CAP: begin
        rdata = {next_capability_pointer, `CAP_VER_VALUE,
          `CAP_ID_VALUE};
      end
      `OFF_SER_LOW: rdata = serial_number_low;
      default: rdata = 32'h0000_0000;
    endcase
  end

  assign hit = 1'b1;
  assign err_o = 1'b0; // unmapped words ack with zero, never error

  // one wait state: ack and data registered together
  always @(posedge clk_i) begin
    if (rst_i || cold_rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req && hit;
      if (req && !we_i) begin
        dat_o <= rdata;
      end
    end
  end
endmodule

/* hdl/aer_serial_map.vh */
// offsets, field positions, reset values for the error-report/serial slice
// assumes a 32-bit classic wishbone slave with byte addresses
// Overview of operation
// - set mask bit suppresses matching correctable report
// - masks sticky read-write; advisory mask resets one
// - sticky 5-bit first-error pointer, read-only
// - bit 5 crc generate capable, lockable, one
// - bit 6 sticky crc generate enable
// - bit 7 crc check capable, lockable, one
// - bit 8 sticky crc check enable
// - first uncorrectable header captured in four logs
// - header words at consecutive rising offsets
// - capability identifier three in low sixteen bits
// - capability version one in bits 19:16
// - sticky lockable lower serial number word
// - correctable status bits set, write-one-clear
`ifndef AER_SERIAL_MAP_VH
`define AER_SERIAL_MAP_VH
`define OFF_CORR_STATUS 12'h110
`define OFF_CORR_MASK 12'h114
`define OFF_ERR_CTL 12'h118
`define OFF_HDR_LOG1 12'h11c
`define OFF_HDR_LOG2 12'h120
`define OFF_HDR_LOG3 12'h124
`define OFF_HDR_LOG4 12'h128
`define OFF_UNCORR_STATUS 12'h104
`define OFF_LOCK_CTL 12'h140
`define OFF_SER_CAP 12'h180
`define OFF_SER_LOW 12'h184
`define CORR_USED_MASK 32'h0000_31c1
`define CORR_MASK_RESET 32'h0000_2000
`define UNCORR_USED_MASK 32'h001f_f010
`define CTL_FEP_LSB 0
`define CTL_GEN_CAP 5
`define CTL_GEN_EN 6
`define CTL_CHK_CAP 7
`define CTL_CHK_EN 8
`define CAP_ID_VALUE 16'h0003
`define CAP_VER_VALUE 4'h1
`define NEXT_PTR_RESET 12'h000
`endif

/* hdl/corr_status_bank.v */
// sticky write-one-to-clear correctable status with per-bit masking
// assumes event pulses are synchronous to clk_i
`timescale 1ns/1ns
module corr_status_bank #(
  parameter WIDTH = 32
) (
  // clock and resets
  input wire clk_i,
  input wire cold_rst_i,
  // events and software clear
  input wire [WIDTH-1:0] event_i,
  input wire [WIDTH-1:0] clear_i,
  input wire [WIDTH-1:0] mask_i,
  input wire [WIDTH-1:0] used_i,
  // state
  output wire [WIDTH-1:0] status_o,
  output wire report_o
);
  reg [WIDTH-1:0] status;
  genvar g;
  // set wins over clear so an event in the clearing cycle is kept
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : bits
      always @(posedge clk_i) begin
        if (cold_rst_i) begin
          status[g] <= 1'b0;
        end else if (used_i[g] && event_i[g]) begin
          status[g] <= 1'b1;
        end else if (clear_i[g]) begin
          status[g] <= 1'b0;
        end
      end
    end
  endgenerate
  assign status_o = status & used_i;
  // masked events never reach the root complex
  assign report_o = |(event_i & used_i & ~mask_i);
endmodule

/* hdl/first_error_log.v */
// first-error capture: pointer and four header words, sticky
// assumes err_bit_i holds the uncorrectable status position of err_i
`timescale 1ns/1ns
module first_error_log #(
  parameter DW = 32
) (
  // clock and resets
  input wire clk_i,
  input wire cold_rst_i,
  // error report from the link
  input wire err_i,
  input wire [4:0] err_bit_i,
  input wire [4*DW-1:0] header_i,
  input wire rearm_i,
  // captured state
  output reg [4:0] pointer_o,
  output reg [4*DW-1:0] log_o,
  output reg held_o
);
  // only the first report is logged until software rearms
  always @(posedge clk_i) begin
    if (cold_rst_i) begin
      pointer_o <= 5'h00;
      log_o <= {4*DW{1'b0}};
      held_o <= 1'b0;
    end else if (err_i && !held_o) begin
      pointer_o <= err_bit_i;
      log_o <= header_i;
      held_o <= 1'b1;
    end else if (rearm_i) begin
      held_o <= 1'b0;
    end
  end
endmodule
